// File: inc/fn_pll_pkg.sv
// shared constants for the fractional-n divider core
package fn_pll_pkg;
  localparam int          N_INT_W         = 8;      // integer divide word width
  localparam int          FRACTION_W      = 12;     // numerator and modulus width
  localparam int          REF_DIV_W       = 4;      // reference counter width
  localparam int          TIMER_W         = 10;     // fast-lock timer width
  localparam int          CP_CELLS        = 64;     // charge-pump cell count
  localparam logic [2:0]  CP_STEPS        = 3'h6;   // binary steps 64 down to 1
  localparam logic [1:0]  TIMER_DIV_LAST  = 2'h3;   // timer clock is quarter rate
  localparam logic [7:0]  N_INT_MIN       = 8'h1a;  // least integer word, 26
  localparam logic [7:0]  N_INT_MAX       = 8'hff;  // largest integer word, 255
  localparam logic [7:0]  PRESC_89_ABOVE  = 8'h50;  // 8/9 needed above 80
  localparam logic [3:0]  REF_DIV_ONE     = 4'h1;   // zero word treated as one

  // fast-lock sequencer states
  typedef enum logic [2:0] {
    FL_IDLE = 3'b001,
    FL_WIDE = 3'b010,
    FL_STEP = 3'b100
  } fast_lock_state_t;
endpackage

// File: hdl/sigma_delta_mash3.sv
// third-order mash sigma-delta interpolator for the feedback divider
`timescale 1ns/1ns
module sigma_delta_mash3
  import fn_pll_pkg::*;
#(
  parameter int W = FRACTION_W
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic               step,        // one pulse per feedback cycle
  input  wire logic [W-1:0]       numerator,   // fractional numerator
  input  wire logic [W-1:0]       modulus,     // fractional modulus
  output logic signed [3:0]       offset       // divide offset, -3 .. +4
);
  // elaboration check on accumulator width
  if (W < 2 || W > 16) begin : g_bad_w
    $error("sigma_delta_mash3: width out of range");
  end

  // modular accumulate, carry out in the top bit
  function automatic logic [W:0] acc_step(input logic [W-1:0] acc,
                                          input logic [W-1:0] add,
                                          input logic [W-1:0] lim);
    logic [W:0] sum;
    sum = {1'b0, acc} + {1'b0, add};
    if (sum >= {1'b0, lim}) begin
      acc_step = {1'b1, W'(sum - {1'b0, lim})};
    end else begin
      acc_step = {1'b0, sum[W-1:0]};
    end
  endfunction

  logic [W-1:0]   acc1_r, acc2_r, acc3_r;  // stage accumulators
  logic [W:0]     s1, s2, s3;              // stage results
  logic           c2d_r, c3d_r, c3dd_r;    // carry history
  logic signed [3:0] offset_nxt;           // combined noise-shaped output

  // cascade: each stage integrates the residue of the one before
  always_comb begin
    s1 = acc_step(acc1_r, numerator, modulus);
    s2 = acc_step(acc2_r, s1[W-1:0], modulus);
    s3 = acc_step(acc3_r, s2[W-1:0], modulus);
    offset_nxt = 4'(signed'({3'h0, s1[W]}))
               + 4'(signed'({3'h0, s2[W]})) - 4'(signed'({3'h0, c2d_r}))
               + 4'(signed'({3'h0, s3[W]})) - 4'(signed'({2'h0, c3d_r, 1'b0}))
               + 4'(signed'({3'h0, c3dd_r}));
  end

  // accumulators advance once per feedback cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc1_r <= '0;
      acc2_r <= '0;
      acc3_r <= '0;
      c2d_r  <= 1'b0;
      c3d_r  <= 1'b0;
      c3dd_r <= 1'b0;
      offset <= 4'sh0;
    end else if (clk_en && step) begin
      acc1_r <= s1[W-1:0];
      acc2_r <= s2[W-1:0];
      acc3_r <= s3[W-1:0];
      c2d_r  <= s2[W];
      c3d_r  <= s3[W];
      c3dd_r <= c3d_r;
      offset <= offset_nxt;
    end
  end
endmodule

// File: hdl/fractional_n_pll_divider.sv
// digital core of a fractional-n synthesizer: dividers, phase detector, fast lock
//
// What this block does
// RULE_01 - reference falling edge drives detector reference side
// RULE_02 - reference divided by programmable 4-bit count
// RULE_03 - optional toggle halves divider output, even duty
// RULE_04 - timer clock from detector reference falling edge
// RULE_05 - software enables toggle for even divide above 2
// RULE_06 - software enables toggle above 120 MHz reference
// RULE_07 - optional doubler ahead of reference divider
// RULE_08 - prescaler 4/5 or 8/9, 8/9 above 80
// RULE_09 - integer divide word limited to 26 through 255
// RULE_10 - third-order sigma-delta varies integer divide value
// RULE_11 - average divide is integer plus numerator over modulus
// RULE_12 - software sets modulus before integer and numerator
// RULE_13 - detector emits up and down pulses
// RULE_14 - lagging feedback gives up, leading gives down
// RULE_15 - all 64 cells in fast lock, one normally
// RULE_16 - power-down closes bypass, opens both path switches
// RULE_17 - wide bandwidth during change, narrow after lock
// RULE_18 - quarter-rate timers start on new frequency
// RULE_19 - pump timer expiry steps cells down over six
// RULE_20 - filter switches closed while their timers run
// RULE_21 - modulator updates once per feedback cycle
// RULE_22 - software keeps numerator below modulus
`timescale 1ns/1ns
module fractional_n_pll_divider
  import fn_pll_pkg::*;
#(
  parameter int TW = TIMER_W,
  parameter int FW = FRACTION_W
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  input  wire logic                 reference_clock_input,     // sampled reference level
  input  wire logic                 fb_prescaler_in,           // prescaled oscillator level
  input  wire logic                 power_down,                // isolate reference input
  input  wire logic                 doubler_en,                // count both reference edges
  input  wire logic                 ref_toggle_en,             // divide-by-2 toggle stage
  input  wire logic [REF_DIV_W-1:0] ref_div_word,              // reference divide, 0 acts as 1
  input  wire logic                 prescaler_89_sel,          // 1 selects 8/9
  input  wire logic [N_INT_W-1:0]   n_integer_word,            // integer divide word
  input  wire logic [FW-1:0]        fractional_numerator_word, // fraction numerator
  input  wire logic [FW-1:0]        fractional_modulus_word,   // fraction modulus
  input  wire logic                 new_freq_strobe,           // pulse: new channel written
  input  wire logic [TW-1:0]        pump_current_timer,        // pump timer load value
  input  wire logic [TW-1:0]        switch_a_timer,            // filter switch a load value
  input  wire logic [TW-1:0]        switch_b_timer,            // filter switch b load value
  output logic                      detector_ref_clk,          // divided reference
  output logic                      pump_up,                   // detector up pulse
  output logic                      pump_down,                 // detector down pulse
  output logic [CP_CELLS-1:0]       cp_cell_en,                // charge-pump cell enables
  output logic                      loop_filter_short_switch_a,
  output logic                      loop_filter_short_switch_b,
  output logic                      ref_input_path_switch_a,
  output logic                      ref_input_path_switch_b,
  output logic                      ref_input_bypass_switch,
  output logic                      prescaler_89_active,       // prescaler modulus in use
  output logic                      presc_setting_warn,        // 4/5 chosen above 80
  output logic [8:0]                fb_divide_value,           // current instantaneous n
  output logic                      n_range_error,             // integer word below 26
  output logic                      fast_lock_active           // wide bandwidth in force
);
  // elaboration checks
  if (TW < 3 || TW > 16) begin : g_bad_tw
    $error("fractional_n_pll_divider: timer width out of range");
  end
  if (FW < 2 || FW > 16) begin : g_bad_fw
    $error("fractional_n_pll_divider: fraction width out of range");
  end

  // thermometer of 2**lg enabled cells
  function automatic logic [CP_CELLS-1:0] cells_of(input logic [2:0] lg);
    cells_of = {CP_CELLS{1'b1}} >> (7'(CP_CELLS) - (7'h1 << lg));
  endfunction

  logic                 ref_q_r;        // previous reference sample
  logic                 ref_evt;        // active reference edge
  logic [REF_DIV_W-1:0] rcnt_r;         // reference divider count
  logic [REF_DIV_W-1:0] rlast;          // terminal count
  logic                 rdiv_pulse;     // divider terminal event
  logic                 dref_q_r;       // previous divided reference
  logic                 det_ref_evt;    // detector rising reference edge
  logic                 timer_fall;     // divided reference falling edge
  logic [1:0]           tdiv_r;         // quarter-rate prescaler
  logic                 timer_tick;     // timer clock event
  logic                 fb_q_r;         // previous feedback sample
  logic                 fb_edge;        // feedback input rising edge
  logic [8:0]           ncnt_r;         // feedback down counter
  logic                 fb_evt;         // feedback divider output event
  logic signed [3:0]    sd_offset;      // modulator offset
  logic [8:0]           n_nxt;          // next instantaneous n
  fast_lock_state_t     fl_r, fl_nxt;   // fast-lock sequencer
  logic [TW-1:0]        pcnt_r;         // pump timer
  logic [TW-1:0]        sw_a_cnt_r;     // filter switch a timer
  logic [TW-1:0]        sw_b_cnt_r;     // filter switch b timer
  logic [2:0]           cell_lg_r;      // log2 of enabled cells
  logic [2:0]           cell_lg_nxt;

  // RULE_01 falling reference edge
  // RULE_07 doubler adds rising edge
  always_comb begin
    ref_evt = !power_down && ((ref_q_r && !reference_clock_input)
            || (doubler_en && !ref_q_r && reference_clock_input));
    rlast = (ref_div_word == '0) ? '0 : ref_div_word - REF_DIV_ONE;
    rdiv_pulse = ref_evt && (rcnt_r >= rlast);
    det_ref_evt = detector_ref_clk && !dref_q_r;
    timer_fall = dref_q_r && !detector_ref_clk;
    timer_tick = timer_fall && (tdiv_r == TIMER_DIV_LAST);
    fb_edge = fb_prescaler_in && !fb_q_r;
    fb_evt = fb_edge && (ncnt_r <= 9'h1);
    n_nxt = {1'b0, n_integer_word} + 9'(signed'(sd_offset));
  end

  // RULE_02 reference divider count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_q_r <= 1'b0;
      rcnt_r  <= '0;
    end else if (clk_en) begin
      ref_q_r <= reference_clock_input;
      if (rdiv_pulse) begin
        rcnt_r <= '0;
      end else if (ref_evt) begin
        rcnt_r <= rcnt_r + REF_DIV_ONE;
      end
    end
  end

  // RULE_03 toggle stage or single-cycle pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      detector_ref_clk <= 1'b0;
      dref_q_r         <= 1'b0;
    end else if (clk_en) begin
      dref_q_r <= detector_ref_clk;
      if (ref_toggle_en) begin
        detector_ref_clk <= detector_ref_clk ^ rdiv_pulse;
      end else begin
        detector_ref_clk <= rdiv_pulse;
      end
    end
  end

  // RULE_04 timer clock off falling edge, quarter rate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tdiv_r <= 2'h0;
    end else if (clk_en && timer_fall) begin
      tdiv_r <= tdiv_r + 2'h1;
    end
  end

  // RULE_21 feedback counter reloads with modulated n
  // RULE_11 average of n_nxt is integer plus fraction
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_q_r          <= 1'b0;
      ncnt_r          <= 9'h0;
      fb_divide_value <= 9'h0;
    end else if (clk_en) begin
      fb_q_r <= fb_prescaler_in;
      if (fb_evt) begin
        ncnt_r          <= n_nxt;
        fb_divide_value <= n_nxt;
      end else if (fb_edge) begin
        ncnt_r <= ncnt_r - 9'h1;
      end
    end
  end

  // RULE_10 third-order modulator
  sigma_delta_mash3 #(
    .W (FW)
  ) u_sdm (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .step      (fb_evt),
    .numerator (fractional_numerator_word),
    .modulus   (fractional_modulus_word),
    .offset    (sd_offset)
  );

  // RULE_13 up on reference, down on feedback
  // RULE_14 whichever edge comes first wins the net pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else if (clk_en) begin
      if ((pump_up || det_ref_evt) && (pump_down || fb_evt)) begin
        pump_up   <= 1'b0;
        pump_down <= 1'b0;
      end else begin
        pump_up   <= pump_up || det_ref_evt;
        pump_down <= pump_down || fb_evt;
      end
    end
  end

  // RULE_08 prescaler select and advisory check
  // RULE_09 integer word range flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescaler_89_active <= 1'b0;
      presc_setting_warn  <= 1'b0;
      n_range_error       <= 1'b0;
    end else if (clk_en) begin
      prescaler_89_active <= prescaler_89_sel;
      presc_setting_warn  <= !prescaler_89_sel && (n_integer_word > PRESC_89_ABOVE);
      n_range_error <= (n_integer_word < N_INT_MIN) || (n_integer_word > N_INT_MAX);
    end
  end

  // RULE_16 reference switches follow power-down
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_input_path_switch_a <= 1'b1;
      ref_input_path_switch_b <= 1'b1;
      ref_input_bypass_switch <= 1'b0;
    end else if (clk_en) begin
      ref_input_path_switch_a <= !power_down;
      ref_input_path_switch_b <= !power_down;
      ref_input_bypass_switch <= power_down;
    end
  end

  // fast-lock sequencer next state
  always_comb begin
    fl_nxt      = fl_r;
    cell_lg_nxt = cell_lg_r;
    case (fl_r)
      FL_IDLE: begin
        cell_lg_nxt = 3'h0;
      end
      FL_WIDE: begin
        // pump timer expiry starts the step-down
        if (timer_tick && pcnt_r <= TW'(1)) begin
          fl_nxt = FL_STEP;
        end
      end
      FL_STEP: begin
        // RULE_19 halve cells on each timer clock
        if (timer_tick) begin
          cell_lg_nxt = cell_lg_r - 3'h1;
          if (cell_lg_r == 3'h1) begin
            fl_nxt = FL_IDLE;
          end
        end
      end
      default: begin
        fl_nxt      = FL_IDLE;
        cell_lg_nxt = 3'h0;
      end
    endcase
    // RULE_18 new frequency restarts wide mode
    if (new_freq_strobe) begin
      fl_nxt      = FL_WIDE;
      cell_lg_nxt = CP_STEPS;
    end
  end

  // RULE_15 cell enables from sequencer
  // RULE_17 wide bandwidth while sequencer busy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fl_r             <= FL_IDLE;
      cell_lg_r        <= 3'h0;
      cp_cell_en       <= {{(CP_CELLS-1){1'b0}}, 1'b1};
      fast_lock_active <= 1'b0;
    end else if (clk_en) begin
      fl_r             <= fl_nxt;
      cell_lg_r        <= cell_lg_nxt;
      cp_cell_en       <= cells_of(cell_lg_nxt);
      fast_lock_active <= (fl_nxt != FL_IDLE) || (sw_a_cnt_r != '0) || (sw_b_cnt_r != '0);
    end
  end

  // RULE_18 timeout counters on quarter-rate ticks
  // RULE_20 switches closed while their counter runs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcnt_r                     <= '0;
      sw_a_cnt_r                 <= '0;
      sw_b_cnt_r                 <= '0;
      loop_filter_short_switch_a <= 1'b0;
      loop_filter_short_switch_b <= 1'b0;
    end else if (clk_en) begin
      if (new_freq_strobe) begin
        pcnt_r     <= pump_current_timer;
        sw_a_cnt_r <= switch_a_timer;
        sw_b_cnt_r <= switch_b_timer;
      end else if (timer_tick) begin
        if (pcnt_r != '0) pcnt_r <= pcnt_r - TW'(1);
        if (sw_a_cnt_r != '0) sw_a_cnt_r <= sw_a_cnt_r - TW'(1);
        if (sw_b_cnt_r != '0) sw_b_cnt_r <= sw_b_cnt_r - TW'(1);
      end
      loop_filter_short_switch_a <= new_freq_strobe ? (switch_a_timer != '0)
                                                    : (sw_a_cnt_r != '0);
      loop_filter_short_switch_b <= new_freq_strobe ? (switch_b_timer != '0)
                                                    : (sw_b_cnt_r != '0);
    end
  end

  // checks
  a_detect_exclusive: assert property ( // RULE_13
    @(posedge clk) disable iff (sys_rst) !(pump_up && pump_down))
    else $error("up and down high together");
  a_lag_gives_up: assert property ( // RULE_14
    @(posedge clk) disable iff (sys_rst)
    clk_en && det_ref_evt && !fb_evt && !pump_down |=> pump_up)
    else $error("reference first did not give up");
  a_lead_gives_down: assert property ( // RULE_14
    @(posedge clk) disable iff (sys_rst)
    clk_en && fb_evt && !det_ref_evt && !pump_up |=> pump_down)
    else $error("feedback first did not give down");
  a_new_freq_wide: assert property ( // RULE_18
    @(posedge clk) disable iff (sys_rst)
    clk_en && new_freq_strobe |=> (cp_cell_en == {CP_CELLS{1'b1}}) && fl_r == FL_WIDE)
    else $error("new frequency did not enable all cells");
  a_idle_one_cell: assert property ( // RULE_15
    @(posedge clk) disable iff (sys_rst)
    fl_r == FL_IDLE && $past(fl_r) == FL_IDLE |-> cp_cell_en == CP_CELLS'(1))
    else $error("normal mode not single cell");
  a_step_halves: assert property ( // RULE_19
    @(posedge clk) disable iff (sys_rst)
    clk_en && fl_r == FL_STEP && timer_tick && !new_freq_strobe
    |=> cell_lg_r == $past(cell_lg_r) - 3'h1)
    else $error("cell step-down not binary");
  a_power_isolate: assert property ( // RULE_16
    @(posedge clk) disable iff (sys_rst)
    clk_en && power_down |=> ref_input_bypass_switch && !ref_input_path_switch_a
                             && !ref_input_path_switch_b)
    else $error("reference not isolated in power-down");
  a_switch_held: assert property ( // RULE_20
    @(posedge clk) disable iff (sys_rst)
    clk_en && !new_freq_strobe && sw_a_cnt_r != '0 |=> loop_filter_short_switch_a)
    else $error("filter switch opened while timer runs");
  a_fb_reload: assert property ( // RULE_21
    @(posedge clk) disable iff (sys_rst)
    clk_en && fb_evt |=> ncnt_r == $past(n_nxt))
    else $error("feedback counter not reloaded");
  a_range_flag: assert property ( // RULE_09
    @(posedge clk) disable iff (sys_rst)
    clk_en && n_integer_word < N_INT_MIN |=> n_range_error)
    else $error("low integer word not flagged");
endmodule

// File: tb/osc_model.sv
// reference oscillator and prescaled oscillator levels seen by the divider core
`timescale 1ns/1ns
module osc_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ref_run,   // reference oscillator running
  input  wire logic       fb_run,    // prescaled oscillator running
  input  wire logic [3:0] ref_half,  // reference half period in clk cycles
  output logic            ref_lvl,   // reference level
  output logic            fb_lvl     // prescaled oscillator level
);
  logic [3:0] ref_cnt_r;  // cycles into reference half period
  logic       fb_cnt_r;   // cycles into feedback half period
  // reference well below limit
  // reference toggles every ref_half cycles and holds its level when stopped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_r <= 4'h0;
      ref_lvl   <= 1'b1;
    end else if (ref_run) begin
      if (ref_cnt_r + 4'h1 >= ref_half) begin
        ref_cnt_r <= 4'h0;
        ref_lvl   <= ~ref_lvl;
      end else begin
        ref_cnt_r <= ref_cnt_r + 4'h1;
      end
    end
  end
  // feedback toggles every second cycle so rising edges are four cycles apart
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_cnt_r <= 1'b0;
      fb_lvl   <= 1'b0;
    end else if (fb_run) begin
      fb_cnt_r <= ~fb_cnt_r;
      if (fb_cnt_r) begin
        fb_lvl <= ~fb_lvl;
      end
    end
  end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the fractional-n divider core
`timescale 1ns/1ns
module tb_top;
  import fn_pll_pkg::*;
  logic        clk, sys_rst, clk_en, pd, dbl, tgl, sel, stb, ref_run, fb_run;
  logic [3:0]  rdiv, rhalf;
  logic [7:0]  nint;
  logic [11:0] num, mdl;
  logic [9:0]  pt, sat, sbt;
  logic        dref, up, dn, swa, swb, pa, pb, byp, p89, warn, nerr, fla, ref_lvl, fb_lvl;
  logic [63:0] cells;
  logic [8:0]  fbdiv;
  logic [31:0] seed = 32'h55;  // xorshift state
  int          error_cnt = 0;
  int          check_count = 0;
  int          a, b, t, rem, k;
  longint      sum;
  fractional_n_pll_divider dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reference_clock_input(ref_lvl), .fb_prescaler_in(fb_lvl), .power_down(pd),
    .doubler_en(dbl), .ref_toggle_en(tgl), .ref_div_word(rdiv), .prescaler_89_sel(sel),
    .n_integer_word(nint), .fractional_numerator_word(num), .fractional_modulus_word(mdl),
    .new_freq_strobe(stb), .pump_current_timer(pt), .switch_a_timer(sat),
    .switch_b_timer(sbt), .detector_ref_clk(dref), .pump_up(up), .pump_down(dn),
    .cp_cell_en(cells), .loop_filter_short_switch_a(swa), .loop_filter_short_switch_b(swb),
    .ref_input_path_switch_a(pa), .ref_input_path_switch_b(pb), .ref_input_bypass_switch(byp),
    .prescaler_89_active(p89), .presc_setting_warn(warn), .fb_divide_value(fbdiv),
    .n_range_error(nerr), .fast_lock_active(fla));
  osc_model osc (.clk(clk), .sys_rst(sys_rst), .ref_run(ref_run), .fb_run(fb_run),
    .ref_half(rhalf), .ref_lvl(ref_lvl), .fb_lvl(fb_lvl));
  // free-running 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // next xorshift value
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // thermometer of k enabled cells
  function automatic logic [63:0] therm(int n);
    return ~64'h0 >> (64 - n);
  endfunction
  // expected detector reference period in clk cycles
  function automatic int exp_per(int r, logic d, logic g);
    return ((r == 0) ? 1 : r) * rhalf * (d ? 1 : 2) * (g ? 2 : 1);
  endfunction
  task automatic check_vec(string nm, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic check_cnt(string nm, int exp, int got);
    check_count++;
    if (got != exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // drive just after a rising edge
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for a detector reference level, sampled on falling edges
  task automatic wait_ref(logic v, output int n);
    n = 0;
    while (dref !== v && n < 500) begin
      @(negedge clk);
      n++;
    end
  endtask
  // high time and period of the detector reference
  task automatic meas(output int per, output int hi);
    int w;
    wait_ref(1'b0, w);
    wait_ref(1'b1, w);
    wait_ref(1'b0, hi);
    wait_ref(1'b1, w);
    per = hi + w;
  endtask
  // bounded wait for a change of the cell enables
  task automatic wait_cells(logic [63:0] old, output int n);
    n = 0;
    while (cells === old && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask
  // next rising edge of the prescaled oscillator
  task automatic fb_edge();
    logic p;
    do begin
      p = fb_lvl;
      @(negedge clk);
    end while (!(fb_lvl === 1'b1 && p === 1'b0));
  endtask
  // detector outputs must never both stand high
  always @(negedge clk) begin
    if (!sys_rst && up === 1'b1 && dn === 1'b1) check_vec("up and down", 64'h0, 64'h1);
  end
  // hang guard, above the worst-case length of all scenarios
  initial begin
    #(95000 * 50);
    error_cnt++;
    summarize();
  end
  initial begin
    {clk_en, sys_rst, pd, dbl, tgl, sel, stb, ref_run, fb_run} = 9'b110000000;
    {rdiv, rhalf, nint, num, mdl} = {4'h1, 4'h6, 8'h1e, 12'h0, 12'h1};
    {pt, sat, sbt} = {10'h3, 10'ha, 10'ha};
    repeat (4) @(negedge clk);
    check_vec("reset cells", 64'h1, cells);
    check_vec("reset path", 64'h3, {byp, pa, pb});
    check_vec("reset lock", 64'h0, {fla, swa, swb});
    step(1);
    sys_rst = 1'b0;
    ref_run = 1'b1;
    // reference divider over random words, doubler and toggle
    for (int i = 0; i < 10; i++) begin
      rdiv = rnd() % 16;
      dbl = rnd() % 2;
      // toggle for even words above two
      tgl = (rdiv > 2 && rdiv % 2 == 0) ? 1'b1 : rnd() % 2;
      meas(a, b);
      meas(a, b);
      check_cnt("ref period", exp_per(rdiv, dbl, tgl), a);
      check_cnt("ref high", tgl ? exp_per(rdiv, dbl, tgl) / 2 : 1, b);
      step(1);
    end
    {rdiv, dbl, tgl} = {4'h1, 1'b0, 1'b0};
    wait_ref(1'b0, a);
    wait_ref(1'b1, a);
    check_vec("ref level at pulse", 64'h0, ref_lvl);
    // feedback stopped, so reference leads and the net pulse is up
    wait_ref(1'b0, a);
    repeat (4) @(negedge clk);
    check_vec("lag up", 64'h2, {up, dn});
    step(1);
    ref_run = 1'b0;
    fb_run = 1'b1;
    t = 0;
    while (!(dn === 1'b1 && up === 1'b0) && t < 2000) begin
      @(negedge clk);
      t++;
    end
    check_vec("lead down", 64'h1, {up, dn});
    // power-down isolates the reference and stops detector events
    step(1);
    {pd, ref_run} = 2'b11;
    t = 0;
    repeat (60) begin
      @(negedge clk);
      if (dref === 1'b1) t++;
    end
    check_vec("pd switches", 64'h4, {byp, pa, pb});
    check_cnt("pd ref pulses", 0, t);
    step(1);
    pd = 1'b0;
    // low clock enable freezes the divider, so no detector pulse appears
    clk_en = 1'b0;
    repeat (40) begin
      @(negedge clk);
      if (dref === 1'b1) t++;
    end
    check_cnt("frozen ref pulses", 0, t);
    step(1);
    clk_en = 1'b1;
    // prescaler and range flags, corners first
    for (int i = 0; i < 14; i++) begin
      nint = (i < 4) ? ((i < 2) ? 8'h19 + i : 8'h50 + i - 2) : rnd();
      sel = rnd() % 2;
      step(2);
      check_vec("prescaler", {sel, 1'b0, 1'b0}, {p89, 1'b0, 1'b0});
      check_vec("presc warn", (!sel && nint > 8'h50), warn);
      check_vec("range flag", (nint < 8'h1a), nerr);
    end
    // fast lock: ticks every 16 cycles with a 4-cycle reference
    {rhalf, ref_run} = {4'h2, 1'b1};
    // switch timers at pump timer plus seven
    {pt, sat, sbt} = {10'h3, 10'ha, 10'ha};
    stb = 1'b1;
    step(1);
    stb = 1'b0;
    wait_cells(~64'h0, a);
    wait_cells(therm(64), a);
    check_vec("step before restart", therm(32), cells);
    step(1);
    stb = 1'b1;
    step(1);
    stb = 1'b0;
    @(negedge clk);
    check_vec("wide on strobe", ~64'h0, cells);
    check_vec("wide switches", 64'h7, {swa, swb, fla});
    t = 0;
    for (k = 32; k >= 1; k = k / 2) begin
      wait_cells(cells, a);
      t = t + a;
      check_vec("cell step", therm(k), cells);
    end
    check_cnt("wide span", 1, (t >= 112 && t <= 176) ? 1 : 0);
    check_vec("switches after step", 64'h7, {swa, swb, fla});
    t = 0;
    while (fla === 1'b1 && t < 400) begin
      @(negedge clk);
      t++;
    end
    check_vec("narrow cells", 64'h1, cells);
    check_vec("narrow switches", 64'h0, {swa, swb, fla});
    // fractional average from a clean start, reset before each of two runs
    for (int i = 0; i < 2; i++) begin
      step(1);
      {sys_rst, fb_run} = 2'b10;
      mdl = rnd() % 4000 + 2;
      num = rnd() % mdl;
      nint = 8'h1a + rnd() % 100;
      sel = (nint > 8'h50);
      step(2);
      {sys_rst, fb_run} = 2'b01;
      rem = 0;
      sum = 0;
      for (int j = 0; j < 64; ) begin
        fb_edge();
        if (rem <= 1) begin
          repeat (2) @(negedge clk);
          rem = fbdiv;
          sum = sum + fbdiv;
          j++;
          check_vec("n in band", 1, fbdiv + 3 >= nint && fbdiv <= nint + 4);
        end else begin
          rem--;
        end
      end
      sum = sum * mdl - 64 * (longint'(nint) * mdl + num);
      sum = (sum < 0) ? -sum : sum;
      check_cnt("average n", 1, (sum <= 8 * longint'(mdl)) ? 1 : 0);
    end
    summarize();
  end
endmodule
